// ===== inc/stsa_defs.svh
// Constants for the test-clock gating and byte-alignment logic.
// Assumes inclusion by bare name from the design files; definitions only.
`ifndef STSA_DEFS_SVH
`define STSA_DEFS_SVH

// Alignment counter
`define STSA_CNT_W 3
`define STSA_CNT_RST 3'h0
`define STSA_CNT_ONE 3'h1
`define STSA_CNT_LAST 3'h7

// Mode register bit positions
`define STSA_M0_TDO_EN 7
`define STSA_M0_TDI_EN 6
`define STSA_M1_TMS0 3
`define STSA_M1_TMS1 4
`define STSA_M2_TCK_EN 0

// Serial input synchroniser depth (flops between pin and logic)
`define STSA_SYNC_LAT 2

// Reset values
`define STSA_BYTE_RST 8'h00
`define STSA_TDO_IDLE 1'b1
`define STSA_TMS_RST 1'b1

`endif

// ===== inc/stsa_pkg.sv
// Types shared by the scan test-clock and alignment logic.
// Assumes nothing of its surroundings.
package stsa_pkg;
  // One serial byte as seen by the host
  typedef logic [7:0] stsa_byte_type;
  // Bit position within a byte
  typedef logic [2:0] stsa_pos_type;
endpackage : stsa_pkg

// ===== logic/stsa_buf2.sv
// Small first-in first-out buffer with valid/ready on both sides.
// Assumes one clock, synchronous active-high reset.
module stsa_buf2 #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 2
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Filling side
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  // Draining side
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [CW-1:0] FULL = CW'(DEPTH);

  // Pointer step with wrap at the depth
  function automatic logic [PW-1:0] ptr_step(input logic [PW-1:0] p);
    ptr_step = (p == PW'(DEPTH - 1)) ? '0 : PW'(p + 1'b1);
  endfunction

  logic [WIDTH-1:0] mem_reg [DEPTH]; // Storage entries
  logic [WIDTH-1:0] mem_next [DEPTH];
  logic [PW-1:0] wptr_reg, wptr_next; // Write index
  logic [PW-1:0] rptr_reg, rptr_next; // Read index
  logic [CW-1:0] cnt_reg, cnt_next; // Entries held
  logic push, pop;

  // Honest full and empty
  assign in_ready = (cnt_reg != FULL);
  assign out_valid = (cnt_reg != '0);
  assign out_data = mem_reg[rptr_reg];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  // Next state of storage and pointers
  always_comb begin
    mem_next = mem_reg;
    wptr_next = wptr_reg;
    rptr_next = rptr_reg;
    cnt_next = cnt_reg;
    if (push) begin
      mem_next[wptr_reg] = in_data;
      wptr_next = ptr_step(wptr_reg);
    end
    if (pop) begin
      rptr_next = ptr_step(rptr_reg);
    end
    if (push && !pop) begin
      cnt_next = CW'(cnt_reg + 1'b1);
    end else if (pop && !push) begin
      cnt_next = CW'(cnt_reg - 1'b1);
    end
  end

  // Register stage
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      wptr_reg <= '0;
      rptr_reg <= '0;
      cnt_reg <= '0;
    end else begin
      wptr_reg <= wptr_next;
      rptr_reg <= rptr_next;
      cnt_reg <= cnt_next;
    end
    mem_reg <= mem_next;
  end
endmodule // stsa_buf2

// ===== logic/stsa_top.sv
// Test-clock gating, serial input sampling and byte alignment for a
// parallel-to-serial scan master. Assumes mode bits and host bytes come
// from logic on sys_clk; tdi comes from the scan chain pins.
`include "stsa_defs.svh"
module stsa_top (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Mode bits from the host
  input wire logic [7:0] mode_reg_zero,
  input wire logic [7:0] mode_reg_one,
  input wire logic [7:0] mode_reg_two,
  // Bytes to shift out
  input wire logic [7:0] tx_data,
  input wire logic tx_valid,
  output logic tx_ready,
  // Bytes shifted in
  output logic [7:0] rx_data,
  output logic rx_valid,
  input wire logic rx_ready,
  // Scan pins
  output logic tck,
  output logic tms0,
  output logic tms1,
  output logic tdo,
  input wire logic tdi,
  // Status
  output logic shifting,
  output logic [2:0] bit_pos
);
  // Last bit of a byte at this position
  function automatic logic at_last(input stsa_pkg::stsa_pos_type p);
    at_last = (p == `STSA_CNT_LAST);
  endfunction

  // Mode decode
  logic tdo_en, tdi_en, tck_en;
  assign tdo_en = mode_reg_zero[`STSA_M0_TDO_EN];
  assign tdi_en = mode_reg_zero[`STSA_M0_TDI_EN];
  assign tck_en = mode_reg_two[`STSA_M2_TCK_EN];

  // Clock run gate and shared counter
  logic run_reg, run_next;
  stsa_pkg::stsa_pos_type cnt_reg, cnt_next;
  // Outgoing shifter
  stsa_pkg::stsa_byte_type txb_reg, txb_next;
  logic txf_reg, txf_next; // Byte loaded
  logic tdo_reg, tdo_next;
  // Incoming path
  logic sync1_reg, sync2_reg; // Pin synchroniser
  logic [`STSA_SYNC_LAT-1:0] take_reg, take_next; // Sample pipeline
  stsa_pkg::stsa_pos_type tpos_reg [`STSA_SYNC_LAT];
  stsa_pkg::stsa_pos_type tpos_next [`STSA_SYNC_LAT];
  stsa_pkg::stsa_byte_type asm_reg, asm_next; // Assembling byte
  stsa_pkg::stsa_byte_type hold_reg, hold_next; // Completed byte
  logic holdf_reg, holdf_next;
  logic tms0_reg, tms0_next, tms1_reg, tms1_next;
  // Buffer handshakes
  stsa_pkg::stsa_byte_type txo_data;
  logic txo_valid, txo_ready, rxi_ready, consume;

  // Outgoing two-entry buffer
  stsa_buf2 #(.WIDTH(8), .DEPTH(2)) u_txbuf (
    .sys_clk(sys_clk), .rst(rst),
    .in_data(tx_data), .in_valid(tx_valid), .in_ready(tx_ready),
    .out_data(txo_data), .out_valid(txo_valid), .out_ready(txo_ready)
  );

  // Incoming two-entry buffer; a host stall backs up into the gate
  stsa_buf2 #(.WIDTH(8), .DEPTH(2)) u_rxbuf (
    .sys_clk(sys_clk), .rst(rst),
    .in_data(hold_reg), .in_valid(holdf_reg), .in_ready(rxi_ready),
    .out_data(rx_data), .out_valid(rx_valid), .out_ready(rx_ready)
  );

  // Test clock stops high; gate changes only while sys_clk is high
  // so the chain never sees a runt pulse as the gate opens or closes
  assign tck = sys_clk | ~run_reg;
  assign tdo = tdo_reg;
  assign tms0 = tms0_reg;
  assign tms1 = tms1_reg;
  assign shifting = run_reg;
  assign bit_pos = cnt_reg;

  // Byte leaves the outgoing shifter at the end of its last bit
  assign consume = run_reg & tdo_en & txf_reg & at_last(cnt_reg);
  // Refill whenever the shifter is empty or being emptied
  assign txo_ready = ~txf_reg | consume;

  // Next values of the shifting logic
  always_comb begin
    // Counter advances per running cycle, wraps, holds when gated
    cnt_next = run_reg ? 3'(cnt_reg + `STSA_CNT_ONE) : cnt_reg;
    // Outgoing byte kept loaded even while disabled
    txb_next = txb_reg;
    txf_next = txf_reg & ~consume;
    if (txo_valid && txo_ready) begin
      txb_next = txo_data;
      txf_next = 1'b1;
    end
    // Bit index is the shared counter, so a mid-byte enable starts there
    if (tdo_en && txf_next) begin
      tdo_next = txb_next[cnt_next];
    end else begin
      tdo_next = `STSA_TDO_IDLE;
    end
    // Sample pipeline covers the synchroniser delay
    // and carries each bit's position tag alongside it
    take_next = {take_reg[`STSA_SYNC_LAT-2:0], run_reg & tdi_en};
    tpos_next[0] = cnt_reg;
    for (int i = 1; i < `STSA_SYNC_LAT; i++) begin
      tpos_next[i] = tpos_reg[i-1];
    end
    // Assemble least significant bit first
    asm_next = asm_reg;
    hold_next = hold_reg;
    holdf_next = holdf_reg & ~rxi_ready;
    if (take_reg[`STSA_SYNC_LAT-1]) begin
      asm_next = {sync2_reg, asm_reg[7:1]};
      // Completion wins over a drain in the same cycle
      if (at_last(tpos_reg[`STSA_SYNC_LAT-1])) begin
        hold_next = {sync2_reg, asm_reg[7:1]};
        holdf_next = 1'b1;
      end
    end
    // Shift gate: mode, outgoing data present, incoming slot free
    // Next-cycle fill is used so bits still in flight never overrun the slot
    run_next = tck_en & (~tdo_en | txf_next) & (~tdi_en | ~holdf_next);
    tms0_next = mode_reg_one[`STSA_M1_TMS0];
    tms1_next = mode_reg_one[`STSA_M1_TMS1];
  end

  // Register stage of the shifting logic
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      run_reg <= 1'b0;
      cnt_reg <= `STSA_CNT_RST;
      txb_reg <= `STSA_BYTE_RST;
      txf_reg <= 1'b0;
      tdo_reg <= `STSA_TDO_IDLE;
      take_reg <= '0;
      for (int i = 0; i < `STSA_SYNC_LAT; i++) begin
        tpos_reg[i] <= `STSA_CNT_RST;
      end
      asm_reg <= `STSA_BYTE_RST;
      hold_reg <= `STSA_BYTE_RST;
      holdf_reg <= 1'b0;
      tms0_reg <= `STSA_TMS_RST;
      tms1_reg <= `STSA_TMS_RST;
    end else begin
      run_reg <= run_next;
      cnt_reg <= cnt_next;
      txb_reg <= txb_next;
      txf_reg <= txf_next;
      tdo_reg <= tdo_next;
      take_reg <= take_next;
      tpos_reg <= tpos_next;
      asm_reg <= asm_next;
      hold_reg <= hold_next;
      holdf_reg <= holdf_next;
      tms0_reg <= tms0_next;
      tms1_reg <= tms1_next;
    end
  end

  // Two-flop pin synchroniser, sampled on sys_clk rising
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      sync1_reg <= 1'b0;
      sync2_reg <= 1'b0;
    end else begin
      sync1_reg <= tdi;
      sync2_reg <= sync1_reg;
    end
  end

  // Checks; the hold slot and gate ones guard against losing a received
  // byte when the host stalls, which no output would show directly
  chk_tck_gate_level: assert property (@(posedge sys_clk) disable iff (rst)
    tck == !run_reg) else $error("test clock not gated by run");

  chk_tdi_sample_bit: assert property (@(posedge sys_clk) disable iff (rst)
    take_reg[`STSA_SYNC_LAT-1] |=> asm_reg[7] == $past(sync2_reg))
    else $error("serial input bit not taken");

  chk_shift_gate_full: assert property (@(posedge sys_clk) disable iff (rst)
    run_reg && $past(tdi_en) |-> !holdf_reg)
    else $error("clock runs with incoming slot full");

  chk_hold_no_clobber: assert property (@(posedge sys_clk) disable iff (rst)
    holdf_reg && !rxi_ready |-> !(take_reg[`STSA_SYNC_LAT-1] &&
      at_last(tpos_reg[`STSA_SYNC_LAT-1])))
    else $error("completed byte lands on a full slot");

  chk_gate_tx_loaded: assert property (@(posedge sys_clk) disable iff (rst)
    run_reg && $past(tdo_en) |-> txf_reg)
    else $error("clock runs with no outgoing byte");

  chk_cnt_shared_step: assert property (@(posedge sys_clk) disable iff (rst)
    run_reg ##1 run_reg |=> cnt_reg == 3'($past(cnt_reg, 2) + 3'h2))
    else $error("alignment counter lost a step");

  chk_tdo_mid_byte: assert property (@(posedge sys_clk) disable iff (rst)
    $past(tdo_en) && txf_reg |-> tdo == txb_reg[cnt_reg])
    else $error("outgoing bit not at counter position");

  chk_tdo_idle_off: assert property (@(posedge sys_clk) disable iff (rst)
    !$past(tdo_en) |-> tdo == `STSA_TDO_IDLE)
    else $error("outgoing pin not idle while disabled");

  chk_cnt_run_step: assert property (@(posedge sys_clk) disable iff (rst)
    run_reg |=> cnt_reg == 3'($past(cnt_reg) + `STSA_CNT_ONE))
    else $error("counter missed a running step");

  chk_cnt_wrap_zero: assert property (@(posedge sys_clk) disable iff (rst)
    run_reg && cnt_reg == 3'h7 |=> cnt_reg == 3'h0)
    else $error("counter did not wrap");

  chk_cnt_hold_gated: assert property (@(posedge sys_clk) disable iff (rst)
    !run_reg |=> $stable(cnt_reg))
    else $error("counter moved while gated");

  chk_rx_stall_keep: assert property (@(posedge sys_clk) disable iff (rst)
    rx_valid && !rx_ready |=> rx_valid && $stable(rx_data))
    else $error("incoming byte lost in stall");
endmodule // stsa_top

// ===== tb/stsa_target.sv
// Scan target model: the last cell of a chain on the scan pins.
// Assumes tck stops high between shifts and rises with sys_clk.
module stsa_target (
  // Scan pins
  input wire logic tck,
  input wire logic tdo,
  output logic tdi,
  // Bytes seen on tdo, toggle marks each new one
  output logic [7:0] cap_byte,
  output logic cap_stb
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] sh_reg; // Capture shifter
  logic [7:0] pat; // Pattern byte being presented
  logic held; // Master output seen mid cycle
  logic armed; // A fall came before this rise
  int n_cap; // Bits captured
  int n_out; // Bits presented

  // Quiet start
  initial begin
    tdi = 1'b0;
    cap_byte = 8'h00;
    cap_stb = 1'b0;
    armed = 1'b0;
    n_cap = 0;
    n_out = 0;
  end

  // Falling edge: note tdo, present next pattern bit
  always @(negedge tck) begin
    held = tdo;
    armed = 1'b1;
    pat = 8'((n_out / 8) * 59) ^ 8'hA5;
    tdi = pat[n_out % 8];
    n_out++;
  end

  // Rising edge: capture, LSB first; a first rise from unknown is ignored
  always @(posedge tck) begin
    if (armed) begin
      sh_reg = {held, sh_reg[7:1]};
      n_cap++;
      armed = 1'b0;
      if (n_cap % 8 == 0) begin
        cap_byte = sh_reg;
        cap_stb = ~cap_stb;
      end
    end
  end
endmodule // stsa_target

// ===== tb/stsa_top_tb.sv
// Bench for the test-clock gating and alignment block.
// Assumes stsa_target stands on the scan pins; inputs change on falling edges.
module stsa_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk = 1'b0; // System clock
  logic rst = 1'b1; // Synchronous reset
  logic [7:0] m0 = 8'h00; // Mode bits
  logic [7:0] m1 = 8'h00;
  logic [7:0] m2 = 8'h00;
  logic [7:0] tx_data = 8'h00; // Host byte
  logic tx_valid = 1'b0;
  logic rx_ready = 1'b0;
  logic tx_ready, rx_valid, tck, tms0, tms1, tdo, tdi, shifting, cap_stb, shift_q;
  logic [7:0] rx_data, cap_byte;
  logic [2:0] bit_pos, pos_q;
  int n_mismatch = 0;
  int checked = 0;
  stsa_pkg::stsa_byte_type tx_q[$]; // Expected bytes on tdo
  stsa_pkg::stsa_byte_type rx_q[$]; // Expected bytes from tdi

  // 100 MHz clock
  always #5 sys_clk = ~sys_clk;

  stsa_top dut (.sys_clk(sys_clk), .rst(rst), .mode_reg_zero(m0), .mode_reg_one(m1),
    .mode_reg_two(m2), .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready),
    .rx_data(rx_data), .rx_valid(rx_valid), .rx_ready(rx_ready), .tck(tck), .tms0(tms0),
    .tms1(tms1), .tdo(tdo), .tdi(tdi), .shifting(shifting), .bit_pos(bit_pos));
  stsa_target chain (.tck(tck), .tdo(tdo), .tdi(tdi), .cap_byte(cap_byte), .cap_stb(cap_stb));

  // Byte comparison
  task automatic cmp_byte(input stsa_pkg::stsa_byte_type got, input stsa_pkg::stsa_byte_type exp);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Flag and position comparison
  task automatic cmp_bits(input logic [2:0] got, input logic [2:0] exp);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Verdict and end of run
  task automatic wrap_up;
    $display("counts: %0d compared, %0d unexpected", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // Offer one byte, held until the buffer takes it
  task automatic send(input stsa_pkg::stsa_byte_type b);
    @(negedge sys_clk);
    while (tx_ready !== 1'b1) @(negedge sys_clk);
    tx_valid = 1'b1;
    tx_data = b;
    @(negedge sys_clk);
    tx_valid = 1'b0;
  endtask

  // Mid-cycle watcher: random receiver stalls, counter, received bytes, gating
  always @(negedge sys_clk) begin
    // Ready is drawn first: the pop happens at the next rising edge with it
    rx_ready = 1'($urandom_range(1));
    if (!rst) begin
      cmp_bits(bit_pos, pos_q + 3'(shift_q));
      if (rx_valid === 1'b1 && rx_ready === 1'b1) begin
        cmp_byte(rx_data, rx_q.pop_front());
      end
    end
    pos_q = bit_pos;
    shift_q = shifting;
    // Gated clock falls in this very time step, so look just after
    #1;
    if (!rst) cmp_bits({2'b00, tck}, {2'b00, !shifting});
  end

  // Bytes the chain captured from tdo
  always @(cap_stb) if (!rst) cmp_byte(cap_byte, tx_q.pop_front());

  // Watchdog
  initial begin
    #200us;
    n_mismatch++;
    wrap_up();
  end

  // Main sequence
  initial begin
    stsa_pkg::stsa_byte_type b;
    b = 8'($urandom(8247));
    repeat (5) @(negedge sys_clk);
    rst = 1'b0;
    m1 = 8'h10;
    cmp_bits({tms1, tms0, tdo}, 3'h7);
    // Fill with the clock gated; first byte is joined mid-byte later
    for (int i = 0; i < 3; i++) begin
      b = 8'($urandom);
      tx_q.push_back(i == 0 ? {b[7:3], 3'h7} : b);
      rx_q.push_back(8'(i * 59) ^ 8'hA5);
      send(b);
    end
    cmp_bits({tms1, tms0, tx_ready}, 3'h4);
    $display("test fill done");
    // Shift in only, then enable the loaded outgoing shifter at position three
    m2 = 8'h01;
    m0 = 8'h40;
    for (int k = 0; k < 200 && bit_pos !== 3'h2; k++) @(negedge sys_clk);
    m0 = 8'hC0;
    for (int k = 0; k < 3000 && (tx_q.size() > 0 || rx_q.size() > 0); k++) @(negedge sys_clk);
    repeat (4) @(negedge sys_clk);
    cmp_bits({2'b00, shifting}, 3'h0);
    cmp_bits(bit_pos, 3'h0);
    cmp_bits(3'(tx_q.size() + rx_q.size()), 3'h0);
    m0 = 8'h00;
    m2 = 8'h00;
    $display("test shift done");
    wrap_up();
  end
endmodule // stsa_top_tb
